// >>> rtl/acmp_pkg.sv
package acmp_pkg;
  // Register offsets in data space
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h50;   // Control and status
  localparam logic [7:0] PIN_DISABLE_OFS = 8'h7f;   // Pin input buffer disable
  // Control/status field positions
  localparam int POWER_OFF_BIT   = 7;               // Comparator power off
  localparam int BANDGAP_BIT     = 6;               // Bandgap replaces positive input
  localparam int RESULT_BIT      = 5;               // Synchronised result, read only
  localparam int IRQ_FLAG_BIT    = 4;               // Sticky event flag
  localparam int IRQ_ENABLE_BIT  = 3;               // Interrupt enable
  localparam int CAPTURE_BIT     = 2;               // Route result to capture unit
  localparam int MODE_HI_BIT     = 1;               // Edge mode field, high bit
  localparam int MODE_LO_BIT     = 0;               // Edge mode field, low bit
  // Pin disable field positions
  localparam int POS_BUF_OFF_BIT = 0;               // Positive pin buffer off
  localparam int NEG_BUF_OFF_BIT = 1;               // Negative pin buffer off
  localparam int PIN_COUNT       = 2;               // Comparator pins
  // Reset values
  localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
  localparam logic [7:0] PIN_DISABLE_RST = 8'h00;
  // Analog level model
  localparam int LEVEL_W      = 10;                 // Width of a sampled voltage code
  localparam int CHANNELS     = 8;                  // Converter channel pins
  localparam int CHAN_SEL_W   = 3;                  // Low channel-select bits
  localparam logic [9:0] BANDGAP_LEVEL = 10'h168;   // Plain default reference code
  // Edge mode codes
  typedef enum logic [1:0] {
    MODE_TOGGLE   = 2'h0,
    MODE_RESERVED = 2'h1,
    MODE_FALLING  = 2'h2,
    MODE_RISING   = 2'h3
  } edge_mode_t;
endpackage : acmp_pkg

// >>> rtl/acmp_front_if.sv
`timescale 1ns/1ns
`default_nettype none
interface acmp_front_if;
  logic                               power_off;       // Comparator switched off
  logic                               bandgap_sel;     // Positive input is bandgap
  logic                               neg_mux_enable;  // Negative input via channel mux
  logic                               converter_enable;// Converter owns the mux
  logic [acmp_pkg::CHAN_SEL_W-1:0]    channel_sel;     // Channel for negative input
  logic                               result;          // Synchronised compare result

  // Control side drives selections, reads result
  modport ctrl (output power_off, bandgap_sel, neg_mux_enable, converter_enable, channel_sel,
                input result);
  // Front end takes selections, returns result
  modport front (input power_off, bandgap_sel, neg_mux_enable, converter_enable, channel_sel,
                 output result);
endinterface : acmp_front_if
`default_nettype wire

// >>> rtl/acmp_front.sv
`timescale 1ns/1ns
`default_nettype none
module acmp_front (
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  // Sampled analog levels
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  positive_input_pin_i,
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  negative_input_pin_i,
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  chan_level_i [acmp_pkg::CHANNELS],
  // Control link
  acmp_front_if.front                        fr
);
  // Mux path only when enabled and the converter is off
  wire logic                         use_chan;
  wire logic [acmp_pkg::LEVEL_W-1:0] pos_level;   // Selected positive level
  wire logic [acmp_pkg::LEVEL_W-1:0] neg_level;   // Selected negative level
  wire logic                         raw_cmp;     // Unsynchronised compare
  logic                              sync1_ff;    // First synchroniser stage
  logic                              sync2_ff;    // Second synchroniser stage

  assign use_chan  = fr.neg_mux_enable & ~fr.converter_enable;                   // [RULE_02]
  assign neg_level = use_chan ? chan_level_i[fr.channel_sel]                    // [RULE_02]
                              : negative_input_pin_i;                           // [RULE_03]
  assign pos_level = fr.bandgap_sel ? acmp_pkg::BANDGAP_LEVEL                   // [RULE_06]
                                    : positive_input_pin_i;
  assign raw_cmp   = (pos_level > neg_level);                                   // [RULE_01]

  // Two-stage synchroniser, held low while powered off
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || fr.power_off) begin
      sync1_ff <= 1'b0;                                                         // [RULE_18]
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_cmp;                                                      // [RULE_07]
      sync2_ff <= sync1_ff;
    end
  end

  assign fr.result = sync2_ff;
endmodule : acmp_front
`default_nettype wire

// >>> rtl/analog_comparator_ctrl.sv
// Behaviour
// RULE_01: Result high when positive exceeds negative.
// RULE_02: Mux on, converter off: channel pick.
// RULE_03: Otherwise dedicated negative pin is used.
// RULE_04: Power-off bit switches comparator off anytime.
// RULE_05: Software drops irq enable before power change.
// RULE_06: Bandgap select replaces positive pin input.
// RULE_07: Result synchronised, one to two cycles.
// RULE_08: Matching edge event sets irq flag.
// RULE_09: Flag clears on vector taken or write-one.
// RULE_10: Request needs flag, enable, global enable.
// RULE_11: Capture enable feeds result to timer.
// RULE_12: Capture disabled: no timer connection.
// RULE_13: Mode: toggle, reserved, falling, rising.
// RULE_14: Software drops irq enable before mode change.
// RULE_15: Buffer disable bits force pin reads zero.
// RULE_16: Software clears converter power reduction first.
// RULE_17: Edge against previous cycle; reserved never sets.
// RULE_18: Powered off: result zero, no edges.
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_ctrl (
  // Clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          rstn_i,
  // Register port
  input  wire logic [7:0]                    addr_i,
  input  wire logic                          wr_en_i,
  input  wire logic                          rd_en_i,
  input  wire logic [7:0]                    wdata_i,
  output logic [7:0]                         rdata_o,
  // Sampled analog levels
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  positive_input_pin_i,
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  negative_input_pin_i,
  input  wire logic [acmp_pkg::LEVEL_W-1:0]  chan_level_i [acmp_pkg::CHANNELS],
  // Converter settings seen by the comparator
  input  wire logic                          neg_mux_enable_i,
  input  wire logic                          converter_enable_i,
  input  wire logic [acmp_pkg::CHAN_SEL_W-1:0] channel_select_low_i,
  // Interrupt handshake with the core
  input  wire logic                          global_irq_enable_i,
  input  wire logic                          irq_taken_i,
  output logic                               irq_req_o,
  // Timer capture front end
  output logic                               capture_o,
  // Comparator pin digital inputs
  input  wire logic [acmp_pkg::PIN_COUNT-1:0] pin_digital_i,
  output logic [acmp_pkg::PIN_COUNT-1:0]     pin_digital_o,
  // Analog power control
  output logic                               comparator_power_off_o
);
  // The front end picks the levels, compares them and synchronises the result.
  // This module owns the registers, the event flag and every output.
  // Each output leaves through a flip-flop, so what the core and the timer see
  // lags the synchronised result by one more edge.

  // Control/status fields, changed only by the write strobe, except the flag
  // The result is not stored here; the flag is
  logic                              power_off_ff;       // Comparator power off
  logic                              bandgap_ff;         // Bandgap select
  logic                              flag_ff;            // Sticky event flag
  logic                              irq_en_ff;          // Interrupt enable
  logic                              capture_en_ff;      // Capture routing enable
  acmp_pkg::edge_mode_t              mode_ff;            // Edge mode
  logic [acmp_pkg::PIN_COUNT-1:0]    buf_off_ff;         // Pin buffer disable bits
  logic                              prev_ff;            // Result one cycle earlier
  logic [7:0]                        rdata_ff;           // Read data
  logic                              irq_ff;             // Interrupt request
  logic                              capture_ff;         // Capture feed
  logic [acmp_pkg::PIN_COUNT-1:0]    pin_ff;             // Gated pin reads

  // Decodes and next values
  // Next values of the flag and output bank are named wires, so that clocked bank stays plain
  wire logic                         sel_ctrl;           // Control/status addressed
  wire logic                         sel_pins;           // Pin disable addressed
  wire logic                         wr_ctrl;            // Control/status write
  wire logic                         wr_pins;            // Pin disable write
  wire logic                         rise;               // Rising edge seen
  wire logic                         fall;               // Falling edge seen
  wire logic                         event_hit;          // Event matches mode
  wire logic                         flag_clr;           // Flag clear request
  wire logic                         nxt_flag;           // Next flag value
  wire logic [7:0]                   ctrl_view;          // Control/status read view
  wire logic [7:0]                   pins_view;          // Pin disable read view
  wire logic [7:0]                   nxt_rdata;          // Next read data
  wire logic [acmp_pkg::PIN_COUNT-1:0] nxt_pin;          // Next gated pin reads
  wire logic                         result;             // Synchronised result
  wire logic                         nxt_irq;            // Next request level
  wire logic                         nxt_capture;        // Next capture feed

  // Front end with input selection and synchroniser
  // Converter settings come from the converter's own registers; this block
  // only watches them and never writes them back
  acmp_front_if fif ();

  assign fif.power_off        = power_off_ff;                                   // [RULE_04]
  assign fif.bandgap_sel      = bandgap_ff;                                     // [RULE_06]
  assign fif.neg_mux_enable   = neg_mux_enable_i;                               // [RULE_02]
  assign fif.converter_enable = converter_enable_i;                             // [RULE_03]
  assign fif.channel_sel      = channel_select_low_i;
  assign result               = fif.result;

  acmp_front u_front (
    .sys_clk_i            (sys_clk_i),
    .rstn_i               (rstn_i),
    .positive_input_pin_i (positive_input_pin_i),
    .negative_input_pin_i (negative_input_pin_i),
    .chan_level_i         (chan_level_i),
    .fr                   (fif.front)
  );

  // Address decode
  // Full byte compared, so no alias of either register exists
  assign sel_ctrl = (addr_i == acmp_pkg::CTRL_STATUS_OFS);
  assign sel_pins = (addr_i == acmp_pkg::PIN_DISABLE_OFS);
  assign wr_ctrl  = wr_en_i & sel_ctrl;
  assign wr_pins  = wr_en_i & sel_pins;

  // Edge detection against the previous result, gated while powered off
  // Both detectors see the synchronised result only, so a glitch on the raw
  // compare that misses the synchroniser never becomes an event.
  // The forced low while powered off would look like a falling edge; the
  // power-off gate hides it. A rise after power returns is a real event, so
  // software keeps the interrupt disabled across that change.
  assign rise = result & ~prev_ff & ~power_off_ff;                               // [RULE_17]
  assign fall = ~result & prev_ff & ~power_off_ff;                               // [RULE_18]

  // Mode match; reserved code never fires
  // Toggle takes either edge; the reserved code matches no term below
  assign event_hit = (mode_ff == acmp_pkg::MODE_TOGGLE  && (rise | fall)) ||     // [RULE_13]
                     (mode_ff == acmp_pkg::MODE_FALLING && fall) ||              // [RULE_13]
                     (mode_ff == acmp_pkg::MODE_RISING  && rise);                // [RULE_17]

  // Clear by vector taken or by writing one; a same-cycle event wins
  // Writing zero to the flag position leaves the flag alone
  assign flag_clr = irq_taken_i | (wr_ctrl & wdata_i[acmp_pkg::IRQ_FLAG_BIT]);   // [RULE_09]
  assign nxt_flag = event_hit | (flag_ff & ~flag_clr);                           // [RULE_08]

  // Read views, reserved bits zero
  // Read data is zero with no read strobed, so the data bus can merge this
  // block with its neighbours without a select
  assign ctrl_view = {power_off_ff, bandgap_ff, result, flag_ff,
                      irq_en_ff, capture_en_ff, mode_ff};
  assign pins_view = {6'h00, buf_off_ff};
  assign nxt_rdata = !rd_en_i ? 8'h00 :
                     sel_ctrl ? ctrl_view :
                     sel_pins ? pins_view : 8'h00;

  // Request needs flag, both enables and no vector being taken
  assign nxt_irq     = nxt_flag & irq_en_ff & global_irq_enable_i & ~irq_taken_i; // [RULE_10]
  // Capture feed carries the result only while routing is on
  assign nxt_capture = capture_en_ff & result;                                   // [RULE_11] [RULE_12]

  // Pin buffer gating, one per comparator pin
  // A disabled buffer reads zero whatever level sits on the pin
  genvar gi;
  generate
    for (gi = 0; gi < acmp_pkg::PIN_COUNT; gi++) begin : g_pin
      assign nxt_pin[gi] = pin_digital_i[gi] & ~buf_off_ff[gi];                  // [RULE_15]
    end
  endgenerate

  // Control/status register
  // Result and flag positions of the write data are not stored here
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      power_off_ff  <= acmp_pkg::CTRL_STATUS_RST[acmp_pkg::POWER_OFF_BIT];
      bandgap_ff    <= acmp_pkg::CTRL_STATUS_RST[acmp_pkg::BANDGAP_BIT];
      irq_en_ff     <= acmp_pkg::CTRL_STATUS_RST[acmp_pkg::IRQ_ENABLE_BIT];
      capture_en_ff <= acmp_pkg::CTRL_STATUS_RST[acmp_pkg::CAPTURE_BIT];
      mode_ff       <= acmp_pkg::MODE_TOGGLE;
    end else if (wr_ctrl) begin
      power_off_ff  <= wdata_i[acmp_pkg::POWER_OFF_BIT];                         // [RULE_04]
      bandgap_ff    <= wdata_i[acmp_pkg::BANDGAP_BIT];
      irq_en_ff     <= wdata_i[acmp_pkg::IRQ_ENABLE_BIT];
      capture_en_ff <= wdata_i[acmp_pkg::CAPTURE_BIT];
      mode_ff       <= acmp_pkg::edge_mode_t'(wdata_i[acmp_pkg::MODE_HI_BIT:acmp_pkg::MODE_LO_BIT]);
    end
  end

  // Pin disable register
  // Only the two low bits exist; the upper bits read zero
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      buf_off_ff <= acmp_pkg::PIN_DISABLE_RST[acmp_pkg::PIN_COUNT-1:0];
    end else if (wr_pins) begin
      buf_off_ff <= wdata_i[acmp_pkg::NEG_BUF_OFF_BIT:acmp_pkg::POS_BUF_OFF_BIT];
    end
  end

  // Flag, edge history and registered outputs
  // The flag is sticky: an event sets it, a taken vector or a write of one
  // clears it. When both land on one edge the event wins, so no edge is lost
  // between the handler clearing the flag and the next comparator change.
  // The request drops on the edge the vector is taken, so the core never
  // sees the same event twice while the flag clears.
  // Edge history follows the result every edge, powered or not.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flag_ff    <= 1'b0;
      prev_ff    <= 1'b0;
      rdata_ff   <= 8'h00;
      irq_ff     <= 1'b0;
      capture_ff <= 1'b0;
      pin_ff     <= '0;
    end else begin
      flag_ff    <= nxt_flag;                                                    // [RULE_08]
      prev_ff    <= result;                                                      // [RULE_17]
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;                                                     // [RULE_10]
      capture_ff <= nxt_capture;                                                 // [RULE_11] [RULE_12]
      pin_ff     <= nxt_pin;                                                     // [RULE_15]
    end
  end

  // Outputs straight from flip-flops
  // Nothing combinational reaches a pin, so the core and timer see clean levels
  assign rdata_o                = rdata_ff;
  assign irq_req_o              = irq_ff;
  assign capture_o              = capture_ff;
  assign pin_digital_o          = pin_ff;
  assign comparator_power_off_o = power_off_ff;                                  // [RULE_04]
endmodule : analog_comparator_ctrl
`default_nettype wire

// >>> bench/acmp_sva.sv
`timescale 1ns/1ns
`default_nettype none
module acmp_sva (
  // Clock, reset and register port
  input wire logic                            sys_clk_i,
  input wire logic                            rstn_i,
  input wire logic [7:0]                      addr_i,
  input wire logic                            wr_en_i,
  input wire logic                            rd_en_i,
  input wire logic [7:0]                      wdata_i,
  input wire logic [7:0]                      rdata_o,
  // Core, timer and pins
  input wire logic                            global_irq_enable_i,
  input wire logic                            irq_taken_i,
  input wire logic                            irq_req_o,
  input wire logic                            capture_o,
  input wire logic [acmp_pkg::PIN_COUNT-1:0]  pin_digital_o,
  input wire logic                            comparator_power_off_o
);
  logic [7:0] ctl_ff;                                      // Shadow of writable controls
  wire ctl_wr = wr_en_i && addr_i == acmp_pkg::CTRL_STATUS_OFS;  // Control write
  wire dis_wr = wr_en_i && addr_i == acmp_pkg::PIN_DISABLE_OFS;  // Pin disable write
  // Shadow follows control writes, flag and result excluded
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) ctl_ff <= 8'h00;
    else if (ctl_wr) ctl_ff <= wdata_i & 8'hcf;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Both pin buffers switched off
  sequence pins_off_s;
    dis_wr && wdata_i[1:0] == 2'h3;
  endsequence
  // Reserved mode armed, request low, no writes
  sequence quiet_reserved_s;
    (ctl_ff[1:0] == 2'h1 && ctl_ff[3] && global_irq_enable_i && !wr_en_i) [*2] ##0 !irq_req_o;
  endsequence
  pin_gate_a: assert property (pins_off_s |-> ##2 pin_digital_o == 2'h0)
    else $error("pin reads not gated");
  high_bits_a: assert property (rd_en_i && addr_i == acmp_pkg::PIN_DISABLE_OFS |=> rdata_o[7:2] == 6'h00)
    else $error("pin disable upper bits set");
  power_out_a: assert property (ctl_wr && wdata_i[7] |-> ##2 comparator_power_off_o)
    else $error("power off not driven");
  off_quiet_a: assert property (ctl_ff[7] [*3] |=> !capture_o)
    else $error("capture active while off");
  cap_route_a: assert property (!ctl_ff[2] |=> !capture_o)
    else $error("capture active while unrouted");
  global_gate_a: assert property (!global_irq_enable_i |=> !irq_req_o)
    else $error("request without global enable");
  enable_gate_a: assert property (!ctl_ff[3] && !ctl_wr |=> !irq_req_o)
    else $error("request without enable");
  taken_clr_a: assert property (irq_taken_i |=> !irq_req_o)
    else $error("request after vector taken");
  reserved_mode_a: assert property (quiet_reserved_s |=> !irq_req_o)
    else $error("reserved mode raised request");
endmodule : acmp_sva
bind analog_comparator_ctrl acmp_sva acmp_sva_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .global_irq_enable_i(global_irq_enable_i), .irq_taken_i(irq_taken_i), .irq_req_o(irq_req_o),
  .capture_o(capture_o), .pin_digital_o(pin_digital_o),
  .comparator_power_off_o(comparator_power_off_o));
`default_nettype wire

// >>> bench/acmp_analog_model.sv
`timescale 1ns/1ns
`default_nettype none
module acmp_analog_model (
  // Clock and timer capture input
  input  wire logic                         sys_clk_i,
  input  wire logic                         capture_i,
  // Analog levels and raw pin reads
  output logic [acmp_pkg::LEVEL_W-1:0]      pos_level_o,
  output logic [acmp_pkg::LEVEL_W-1:0]      neg_level_o,
  output logic [acmp_pkg::LEVEL_W-1:0]      chan_level_o [acmp_pkg::CHANNELS],
  output logic [acmp_pkg::PIN_COUNT-1:0]    pin_raw_o,
  output int                                capture_edges_o
);
  logic cap_prev;                           // Capture input one cycle back
  // Channel ladder from 0x20 in 0x40 steps, positive pin low, negative pin high, raw pin reads low
  initial begin
    for (int i = 0; i < acmp_pkg::CHANNELS; i++) chan_level_o[i] = 10'(i * 64 + 32);
    pos_level_o = 10'h000;
    neg_level_o = 10'h3ff;
    pin_raw_o = 2'h0;
    cap_prev = 1'b0;
    capture_edges_o = 0;
  end
  // Timer front end counts rising capture edges
  always @(posedge sys_clk_i) begin
    cap_prev <= capture_i;
    if (capture_i && !cap_prev) capture_edges_o <= capture_edges_o + 1;
  end
  // Pin levels change when called, without waiting for a clock edge
  task automatic set_levels(input logic [9:0] pos, input logic [9:0] neg);
    pos_level_o <= pos;
    neg_level_o <= neg;
  endtask : set_levels
  // Raw digital pin reads
  task automatic set_pins(input logic [1:0] p);
    pin_raw_o <= p;
  endtask : set_pins
endmodule : acmp_analog_model
`default_nettype wire

// >>> bench/analog_comparator_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_ctrl_tb;
  typedef struct packed {logic mux; logic conv; logic [2:0] sel; logic bg; logic [9:0] pos; logic res;} row_t;
  logic       sys_clk, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, glb = 1'b0, taken = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rd;
  logic [4:0] conv_set = 5'h00;             // Mux enable, converter enable, channel
  logic [9:0] pos, neg, chan [8];
  logic [1:0] pin_raw, pin_out;
  logic       irq, cap, pwr;
  int         n_fail = 0, n_compared = 0, edges;
  // Ordinary cases: pin, mux, ladder, equal and bandgap
  row_t rows [13] = '{'{0,0,0,0,10'h100,0}, '{1,1,0,0,10'h100,0}, '{1,0,0,0,10'h100,1},
    '{1,0,1,0,10'h100,1}, '{1,0,2,0,10'h100,1}, '{1,0,3,0,10'h100,1}, '{1,0,4,0,10'h100,0},
    '{1,0,5,0,10'h100,0}, '{1,0,6,0,10'h100,0}, '{1,0,7,0,10'h100,0}, '{1,0,4,0,10'h120,0},
    '{1,0,5,1,10'h000,1}, '{1,0,6,1,10'h3ff,0}};
  analog_comparator_ctrl analog_comparator_ctrl_inst (.sys_clk_i(sys_clk), .rstn_i(rstn),
    .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
    .positive_input_pin_i(pos), .negative_input_pin_i(neg), .chan_level_i(chan),
    .neg_mux_enable_i(conv_set[4]), .converter_enable_i(conv_set[3]),
    .channel_select_low_i(conv_set[2:0]), .global_irq_enable_i(glb), .irq_taken_i(taken),
    .irq_req_o(irq), .capture_o(cap), .pin_digital_i(pin_raw), .pin_digital_o(pin_out),
    .comparator_power_off_o(pwr));
  acmp_analog_model acmp_analog_model_inst (.sys_clk_i(sys_clk), .capture_i(cap),
    .pos_level_o(pos), .neg_level_o(neg), .chan_level_o(chan), .pin_raw_o(pin_raw),
    .capture_edges_o(edges));
  // Clock at 8 ns
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk
  // One register write
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) {addr, wdata, wr_en} <= {a, d, 1'b1};
    @(posedge sys_clk) wr_en <= 1'b0;
  endtask : reg_wr
  // One register read, data one cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk) {addr, rd_en} <= {a, 1'b1};
    @(posedge sys_clk) rd_en <= 1'b0;
    #1 rd = rdata;
  endtask : reg_rd
  // Settle for n edges
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_n
  // Verdict
  task automatic close_out();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  // Watchdog on the whole run
  initial begin
    wait_n(20000);
    n_fail++;
    close_out();
  end
  // Main sequence
  initial begin
    wait_n(4);
    @(posedge sys_clk) rstn <= 1'b1;
    reg_rd(acmp_pkg::CTRL_STATUS_OFS);
    chk("ctrl reset", acmp_pkg::CTRL_STATUS_RST, rd);
    reg_rd(acmp_pkg::PIN_DISABLE_OFS);
    chk("pin reset", acmp_pkg::PIN_DISABLE_RST, rd);
    foreach (rows[i]) begin
      // Converter power reduction taken as already cleared by software
      @(posedge sys_clk) conv_set <= {rows[i].mux, rows[i].conv, rows[i].sel};
      reg_wr(acmp_pkg::CTRL_STATUS_OFS, {1'b0, rows[i].bg, 6'h00});
      acmp_analog_model_inst.set_levels(rows[i].pos, 10'h3ff);
      wait_n(4);
      reg_rd(acmp_pkg::CTRL_STATUS_OFS);
      chk("result bit", {7'h00, rows[i].res}, {7'h00, rd[5]});
    end
    @(posedge sys_clk) {conv_set, glb} <= {5'h00, 1'b1};
    acmp_analog_model_inst.set_levels(10'h000, 10'h100);
    reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'h00);               // Bandgap off, result settles
    wait_n(4);
    for (int m = 0; m < 4; m++) begin
      reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'(m) | 8'h04);
      reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'(m) | 8'h1c);
      acmp_analog_model_inst.set_levels(10'h200, 10'h100);
      wait_n(4);
      chk("irq on rise", {7'h00, m == 0 || m == 3}, {7'h00, irq});
      chk("capture", 8'h01, {7'h00, cap});
      @(posedge sys_clk) taken <= 1'b1;
      @(posedge sys_clk) taken <= 1'b0;
      wait_n(1);
      chk("irq after taken", 8'h00, {7'h00, irq});
      acmp_analog_model_inst.set_levels(10'h000, 10'h100);
      wait_n(4);
      chk("irq on fall", {7'h00, m == 0 || m == 2}, {7'h00, irq});
      reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'(m) | 8'h1c);
      wait_n(2);
      chk("irq after clear", 8'h00, {7'h00, irq});
    end
    chk("capture edges", 8'h04, 8'(edges));
    // Rising event with the global enable low, then raised
    @(posedge sys_clk) glb <= 1'b0;
    acmp_analog_model_inst.set_levels(10'h200, 10'h100);
    wait_n(4);
    chk("irq masked", 8'h00, {7'h00, irq});
    @(posedge sys_clk) glb <= 1'b1;
    wait_n(1);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'h14);
    reg_wr(acmp_pkg::CTRL_STATUS_OFS, 8'h84);
    acmp_analog_model_inst.set_levels(10'h200, 10'h100);
    wait_n(4);
    reg_rd(acmp_pkg::CTRL_STATUS_OFS);
    chk("powered off", 8'h84, rd);
    chk("power out", 8'h01, {7'h00, pwr});
    chk("capture off", 8'h00, {7'h00, cap});
    acmp_analog_model_inst.set_pins(2'h3);
    reg_wr(acmp_pkg::PIN_DISABLE_OFS, 8'hff);
    reg_rd(acmp_pkg::PIN_DISABLE_OFS);
    chk("pin disable", 8'h03, rd);
    chk("pins gated", 8'h00, {6'h00, pin_out});
    reg_wr(acmp_pkg::PIN_DISABLE_OFS, 8'h01);
    wait_n(2);
    chk("pins half", 8'h02, {6'h00, pin_out});
    reg_rd(8'h51);
    chk("unmapped", 8'h00, rd);
    // Reset again in mid-run
    @(posedge sys_clk) rstn <= 1'b0;
    wait_n(2);
    chk("power out in reset", 8'h00, {7'h00, pwr});
    chk("pins in reset", 8'h00, {6'h00, pin_out});
    @(posedge sys_clk) rstn <= 1'b1;
    reg_rd(acmp_pkg::CTRL_STATUS_OFS);
    chk("ctrl after reset", acmp_pkg::CTRL_STATUS_RST, rd);
    close_out();
  end
endmodule : analog_comparator_ctrl_tb
`default_nettype wire
